// ==== verilog/ring_line_pkg.sv ====
// Shared types and constants for the two-port ring and line forwarding logic.
//
// Overview of operation
// - A slave repeats received data to its other port with constant delay.
// - Same sync telegram type seen on both ports means line topology.
// - Primary on one port and secondary on the other means ring topology.
// - Forwarding sends port one data out port two and the reverse.
// - In the realtime slot forwarded data leaves exactly the forwarding delay plus one output register cycle later.
// - In the IP slot a slave always keeps forwarding enabled.
// - A master blocks forwarding for the whole realtime slot.
// - In IP slot a master blocks forwarding on single line or intact ring.
// - In IP slot a master forwards on two lines or a faulty ring.
// - Loopback sends data received on the chosen port out of both ports.
// - At most one of the two loopback states is ever selected.
// - A slave never loops back while the IP slot is active.
// - Loopback in realtime slot happens only under the listed conditions.
// - In initial phase, loop on first sync port until the other port sees sync.
// - The last node of a line loops back during the realtime slot.
// - Addresses 0 and 255 behave and evaluate sync exactly like any other.
// - In a ring a slave passes each channel copy on within its channel.
// - Reception loss on one port closes loopback on the other port.
// - Line end ports unused for realtime traffic may carry IP traffic.
package ring_line_pkg;

    // ***************************************************************
    // Widths and timing
    // ***************************************************************
    localparam int BEAT_W        = 8;
    localparam int FWD_DELAY_CYC = 4;
    localparam int PORT_COUNT    = 2;
    localparam int PORT_ONE_IDX  = 0;
    localparam int PORT_TWO_IDX  = 1;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic              valid;
        logic [BEAT_W-1:0] data;
    } port_beat_t;

    typedef struct packed {
        logic seen;
        logic primary;
    } sync_ind_t;

    typedef enum logic [1:0] {
        MODE_BLOCK,
        MODE_FORWARD,
        MODE_LOOP_ONE,
        MODE_LOOP_TWO
    } mode_t;

    typedef enum logic [1:0] {
        TOPO_UNKNOWN,
        TOPO_LINE,
        TOPO_RING
    } topo_t;

    localparam port_beat_t BEAT_IDLE = '{valid: 1'b0, data: 8'h00};
    localparam mode_t      MODE_RST  = MODE_FORWARD;
    localparam topo_t      TOPO_RST  = TOPO_UNKNOWN;

endpackage : ring_line_pkg

// ==== verilog/fixed_delay_line.sv ====
// Fixed-length delay line that repeats a port stream a constant number of cycles later.
`timescale 1ns/1ps
module fixed_delay_line
    import ring_line_pkg::*;
#(
    parameter int DEPTH = ring_line_pkg::FWD_DELAY_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire ring_line_pkg::port_beat_t beat_in,
    output ring_line_pkg::port_beat_t      beat_out
);
    import ring_line_pkg::*;

    // ***************************************************************
    // Shift stages
    // ***************************************************************
    // The delay is a plain shift so it never depends on frame content.
    port_beat_t stage_reg  [DEPTH];
    port_beat_t stage_next [DEPTH];

    always_comb begin
        stage_next[0] = beat_in;
        for (int i = 1; i < DEPTH; i++) begin
            stage_next[i] = stage_reg[i-1];
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (sys_rst) begin
                stage_reg[i] <= BEAT_IDLE;
            end else begin
                stage_reg[i] <= stage_next[i];
            end
        end
    end

    assign beat_out = stage_reg[DEPTH-1];

endmodule : fixed_delay_line

// ==== verilog/ring_line_port_forwarding.sv ====
// Port switching, topology detection and loopback control for a two-port participant.
`timescale 1ns/1ps
module ring_line_port_forwarding
    import ring_line_pkg::*;
#(
    parameter int FWD_DELAY = ring_line_pkg::FWD_DELAY_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      is_master,
    input  wire logic                      rt_slot,
    input  wire logic                      initial_comm_phase,
    input  wire logic                      master_ring_intact,
    input  wire logic                      link_up_one,
    input  wire logic                      link_up_two,
    input  wire ring_line_pkg::sync_ind_t  sync_one,
    input  wire ring_line_pkg::sync_ind_t  sync_two,
    input  wire ring_line_pkg::port_beat_t rx_one,
    input  wire ring_line_pkg::port_beat_t rx_two,
    input  wire ring_line_pkg::port_beat_t ip_one,
    input  wire ring_line_pkg::port_beat_t ip_two,
    input  wire logic [1:0]                lost_clear,
    output ring_line_pkg::port_beat_t      tx_one,
    output ring_line_pkg::port_beat_t      tx_two,
    output logic                           ip_one_ready,
    output logic                           ip_two_ready,
    output ring_line_pkg::mode_t           port_mode,
    output ring_line_pkg::topo_t           topology,
    output logic [1:0]                     link_lost
);
    import ring_line_pkg::*;

    // ***************************************************************
    // Repeater delay lines
    // ***************************************************************
    port_beat_t fwd_from_one;
    port_beat_t fwd_from_two;

    fixed_delay_line #(
        .DEPTH    (FWD_DELAY)
    ) delay_one (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .beat_in  (rx_one),
        .beat_out (fwd_from_one)
    );

    fixed_delay_line #(
        .DEPTH    (FWD_DELAY)
    ) delay_two (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .beat_in  (rx_two),
        .beat_out (fwd_from_two)
    );

    // ***************************************************************
    // Sync telegram tracking and topology
    // ***************************************************************
    logic [1:0] seen_reg;
    logic [1:0] seen_next;
    logic [1:0] primary_reg;
    logic [1:0] primary_next;
    topo_t      topo_reg;
    topo_t      topo_next;

    // The device address never enters this evaluation.
    always_comb begin
        seen_next    = seen_reg;
        primary_next = primary_reg;
        topo_next    = TOPO_UNKNOWN;
        if (sync_one.seen) begin
            seen_next[PORT_ONE_IDX]    = 1'b1;
            primary_next[PORT_ONE_IDX] = sync_one.primary;
        end
        if (sync_two.seen) begin
            seen_next[PORT_TWO_IDX]    = 1'b1;
            primary_next[PORT_TWO_IDX] = sync_two.primary;
        end
        // A dead link forgets its sync so a replugged cable is learnt afresh.
        if (!link_up_one) begin
            seen_next[PORT_ONE_IDX] = 1'b0;
        end
        if (!link_up_two) begin
            seen_next[PORT_TWO_IDX] = 1'b0;
        end
        if (seen_reg == 2'b11) begin
            if (primary_reg[0] == primary_reg[1]) begin
                topo_next = TOPO_LINE;
            end else begin
                topo_next = TOPO_RING;
            end
        end else if (seen_reg != 2'b00) begin
            topo_next = TOPO_LINE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seen_reg    <= 2'b00;
            primary_reg <= 2'b00;
            topo_reg    <= TOPO_RST;
        end else begin
            seen_reg    <= seen_next;
            primary_reg <= primary_next;
            topo_reg    <= topo_next;
        end
    end

    // ***************************************************************
    // Link loss flags
    // ***************************************************************
    logic [1:0] link_prev_reg;
    logic [1:0] lost_reg;
    logic [1:0] lost_next;
    logic [1:0] link_now;

    assign link_now = {link_up_two, link_up_one};

    // A falling link in the clearing cycle still leaves the flag set.
    always_comb begin
        lost_next = (lost_reg & ~lost_clear) | (link_prev_reg & ~link_now);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_prev_reg <= 2'b00;
            lost_reg      <= 2'b00;
        end else begin
            link_prev_reg <= link_now;
            lost_reg      <= lost_next;
        end
    end

    // ***************************************************************
    // Delay line fill tracking
    // ***************************************************************
    // After reset the delay lines hold idle beats, not what was received,
    // so the delay check waits until every stage has been refilled.
    logic [7:0] fill_cnt_reg;
    logic [7:0] fill_cnt_next;

    always_comb begin
        fill_cnt_next = fill_cnt_reg;
        if (fill_cnt_reg < 8'(FWD_DELAY)) begin
            fill_cnt_next = fill_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fill_cnt_reg <= 8'h00;
        end else begin
            fill_cnt_reg <= fill_cnt_next;
        end
    end

    // ***************************************************************
    // Port mode selection
    // ***************************************************************
    mode_t mode_reg;
    mode_t mode_next;
    logic  loop_one_cond;
    logic  loop_two_cond;
    logic  master_fwd;

    always_comb begin
        // First sync port loops until the other port hears sync too.
        // A line end, or a healed ring after reception loss, loops on the live port.
        loop_one_cond = (initial_comm_phase && seen_reg[0] && !seen_reg[1])
                      || (!initial_comm_phase && link_up_one && !link_up_two
                          && seen_reg[0]);
        loop_two_cond = (initial_comm_phase && seen_reg[1] && !seen_reg[0])
                      || (!initial_comm_phase && link_up_two && !link_up_one
                          && seen_reg[1]);
        master_fwd    = link_up_one && link_up_two && !master_ring_intact;
        mode_next     = MODE_FORWARD;
        if (is_master) begin
            if (rt_slot) begin
                mode_next = MODE_BLOCK;
            end else if (master_fwd) begin
                mode_next = MODE_FORWARD;
            end else begin
                mode_next = MODE_BLOCK;
            end
        end else if (!rt_slot) begin
            mode_next = MODE_FORWARD;
        end else if (loop_one_cond) begin
            mode_next = MODE_LOOP_ONE;
        end else if (loop_two_cond) begin
            // Port one wins a tie, so both loops can never be chosen together.
            mode_next = MODE_LOOP_TWO;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= MODE_RST;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ***************************************************************
    // Transmit multiplexer
    // ***************************************************************
    port_beat_t tx_one_reg;
    port_beat_t tx_one_next;
    port_beat_t tx_two_reg;
    port_beat_t tx_two_next;
    logic       ip_lane;

    // Local IP only fills idle gaps so repeated traffic is never held back.
    assign ip_lane = !rt_slot && (mode_reg == MODE_FORWARD || mode_reg == MODE_BLOCK);

    always_comb begin
        tx_one_next  = BEAT_IDLE;
        tx_two_next  = BEAT_IDLE;
        ip_one_ready = 1'b0;
        ip_two_ready = 1'b0;
        unique case (mode_reg)
            MODE_BLOCK: begin
                tx_one_next = BEAT_IDLE;
                tx_two_next = BEAT_IDLE;
            end
            MODE_FORWARD: begin
                tx_one_next = fwd_from_two;
                tx_two_next = fwd_from_one;
            end
            MODE_LOOP_ONE: begin
                tx_one_next = fwd_from_one;
                tx_two_next = fwd_from_one;
            end
            MODE_LOOP_TWO: begin
                tx_one_next = fwd_from_two;
                tx_two_next = fwd_from_two;
            end
        endcase
        if (ip_lane && !tx_one_next.valid) begin
            ip_one_ready = 1'b1;
            tx_one_next  = ip_one;
        end
        if (ip_lane && !tx_two_next.valid) begin
            ip_two_ready = 1'b1;
            tx_two_next  = ip_two;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_one_reg <= BEAT_IDLE;
            tx_two_reg <= BEAT_IDLE;
        end else begin
            tx_one_reg <= tx_one_next;
            tx_two_reg <= tx_two_next;
        end
    end

    assign tx_one    = tx_one_reg;
    assign tx_two    = tx_two_reg;
    assign port_mode = mode_reg;
    assign topology  = topo_reg;
    assign link_lost = lost_reg;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    a_master_rt_block: assert property (@(posedge clk) disable iff (sys_rst)
        is_master && rt_slot |=> mode_reg == MODE_BLOCK)
        else $error("Master forwards during realtime slot.");

    a_master_ip_fwd: assert property (@(posedge clk) disable iff (sys_rst)
        is_master && !rt_slot && link_up_one && link_up_two && !master_ring_intact
        |=> mode_reg == MODE_FORWARD)
        else $error("Master does not forward on two lines in IP slot.");

    a_slave_ip_fwd: assert property (@(posedge clk) disable iff (sys_rst)
        !is_master && !rt_slot |=> mode_reg == MODE_FORWARD)
        else $error("Slave left forwarding during IP slot.");

    a_line_detect: assert property (@(posedge clk) disable iff (sys_rst)
        seen_reg == 2'b11 && primary_reg[0] == primary_reg[1] |=> topo_reg == TOPO_LINE)
        else $error("Equal sync types not reported as line.");

    a_ring_detect: assert property (@(posedge clk) disable iff (sys_rst)
        seen_reg == 2'b11 && primary_reg[0] != primary_reg[1] |=> topo_reg == TOPO_RING)
        else $error("Mixed sync types not reported as ring.");

    a_first_sync_loop: assert property (@(posedge clk) disable iff (sys_rst)
        !is_master && rt_slot && initial_comm_phase && seen_reg == 2'b10
        |=> mode_reg == MODE_LOOP_TWO)
        else $error("Initial phase loopback not taken on first sync port.");

    a_heal_loop: assert property (@(posedge clk) disable iff (sys_rst)
        !is_master && rt_slot && !initial_comm_phase && link_up_one && !link_up_two
        && seen_reg[0] |=> mode_reg == MODE_LOOP_ONE)
        else $error("Loopback not closed after reception loss.");

    a_loop_single: assert property (@(posedge clk) disable iff (sys_rst)
        mode_reg == MODE_LOOP_TWO |-> !$past(loop_one_cond))
        else $error("Loopback two chosen while port one qualified.");

    a_fwd_delay: assert property (@(posedge clk) disable iff (sys_rst)
        fill_cnt_reg == 8'(FWD_DELAY) && mode_reg == MODE_FORWARD && rt_slot
        |=> tx_two_reg == $past(rx_one, FWD_DELAY + 1))
        else $error("Forwarded data not at fixed delay.");

    a_loop_copy: assert property (@(posedge clk) disable iff (sys_rst)
        (mode_reg == MODE_LOOP_ONE || mode_reg == MODE_LOOP_TWO) && rt_slot
        |=> tx_one_reg == tx_two_reg)
        else $error("Loopback copies differ between ports.");

    a_lost_flag: assert property (@(posedge clk) disable iff (sys_rst)
        link_prev_reg[0] && !link_up_one |=> lost_reg[0] ##1 lost_reg[0] || $past(lost_clear[0]))
        else $error("Link loss flag not raised or dropped early.");

endmodule : ring_line_port_forwarding

// ==== tb/ring_neighbours.sv ====
// Behavioural model of the neighbouring participants seen on port one and port two.
`timescale 1ns/1ps
module ring_neighbours
    import ring_line_pkg::*;
(
    input  wire logic                clk,
    output ring_line_pkg::port_beat_t rx_one,
    output ring_line_pkg::port_beat_t rx_two,
    output ring_line_pkg::sync_ind_t  sync_one,
    output ring_line_pkg::sync_ind_t  sync_two,
    output logic                      link_up_one,
    output logic                      link_up_two
);
    import ring_line_pkg::*;

    // Port select 0 is port one, 1 is port two, 2 sends one copy on each port.
    task automatic beats(input int p, input logic [7:0] a, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge clk);
            if (p != 1) rx_one = '{valid: 1'b1, data: a + i[7:0]};
            if (p != 0) rx_two = '{valid: 1'b1, data: a + i[7:0]};
        end
        @(negedge clk);
        // An idle line shows the inverse of the last byte, so stale data never passes.
        rx_one = '{valid: 1'b0, data: ~rx_one.data};
        rx_two = '{valid: 1'b0, data: ~rx_two.data};
    endtask : beats

    task automatic sync(input int p, input logic prim);
        @(negedge clk);
        if (p == 0) sync_one = '{seen: 1'b1, primary: prim};
        else sync_two = '{seen: 1'b1, primary: prim};
        @(negedge clk);
        sync_one = '{seen: 1'b0, primary: ~sync_one.primary};
        sync_two = '{seen: 1'b0, primary: ~sync_two.primary};
    endtask : sync

    task automatic link(input int p, input logic up);
        @(negedge clk);
        if (p == 0) link_up_one = up;
        else link_up_two = up;
    endtask : link

    initial begin
        rx_one      = BEAT_IDLE;
        rx_two      = BEAT_IDLE;
        sync_one    = '{seen: 1'b0, primary: 1'b0};
        sync_two    = '{seen: 1'b0, primary: 1'b0};
        link_up_one = 1'b1;
        link_up_two = 1'b1;
    end

endmodule : ring_neighbours

// ==== tb/ring_line_port_forwarding_tb.sv ====
// Self-checking bench for the two-port forwarding, loopback and topology logic.
`timescale 1ns/1ps
module ring_line_port_forwarding_tb;
    import ring_line_pkg::*;

    // A short delay keeps runs quick and proves the parameter is honoured.
    localparam int FD = 3;

    logic       clk, sys_rst, is_master, rt_slot, init_phase, ring_ok;
    logic [1:0] lost_clear, link_lost;
    logic       link_up_one, link_up_two, ip_one_ready, ip_two_ready;
    sync_ind_t  sync_one, sync_two;
    port_beat_t rx_one, rx_two, ip_one, ip_two, tx_one, tx_two;
    mode_t      port_mode;
    topo_t      topology;
    int         error_cnt = 0;
    int         check_count = 0;
    int         cyc = 0;

    ring_line_port_forwarding #(.FWD_DELAY(FD)) ring_line_port_forwarding_inst (
        .clk(clk), .sys_rst(sys_rst), .is_master(is_master), .rt_slot(rt_slot),
        .initial_comm_phase(init_phase), .master_ring_intact(ring_ok),
        .link_up_one(link_up_one), .link_up_two(link_up_two),
        .sync_one(sync_one), .sync_two(sync_two), .rx_one(rx_one), .rx_two(rx_two),
        .ip_one(ip_one), .ip_two(ip_two), .lost_clear(lost_clear),
        .tx_one(tx_one), .tx_two(tx_two), .ip_one_ready(ip_one_ready),
        .ip_two_ready(ip_two_ready), .port_mode(port_mode), .topology(topology),
        .link_lost(link_lost));

    ring_neighbours ring_neighbours_inst (
        .clk(clk), .rx_one(rx_one), .rx_two(rx_two), .sync_one(sync_one),
        .sync_two(sync_two), .link_up_one(link_up_one), .link_up_two(link_up_two));

    always #50 clk = ~clk;

    // ***************************************************************
    // Shared helpers
    // ***************************************************************
    task automatic end_of_test;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // A hung wait must still reach the closing report.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("[ERR] %0t run limit reached", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic do_reset;
        sys_rst = 1'b1;
        tick(10);
        sys_rst = 1'b0;
    endtask : do_reset

    // Two beats from src; e1 and e2 say which ports must repeat them.
    task automatic path(input int src, input logic [7:0] a, input logic e1, input logic e2);
        int   k;
        logic h;
        ring_neighbours_inst.beats(src, a, 2);
        for (k = 3; k <= FD + 4; k++) begin
            @(negedge clk);
            h = (k == FD + 1) || (k == FD + 2);
            chk(tx_one.valid === (e1 & h) && (!(e1 & h) || tx_one.data === a + 8'(k - FD - 1)),
                "tx_one stream wrong");
            chk(tx_two.valid === (e2 & h) && (!(e2 & h) || tx_two.data === a + 8'(k - FD - 1)),
                "tx_two stream wrong");
        end
    endtask : path

    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task automatic t_topology;
        do_reset();
        chk(tx_one.valid === 1'b0 && tx_two.valid === 1'b0, "tx not idle after reset");
        chk(port_mode === MODE_FORWARD && topology === TOPO_UNKNOWN, "reset state");
        chk(link_lost === 2'b00, "loss flags after reset");
        ring_neighbours_inst.sync(0, 1'b1);
        ring_neighbours_inst.sync(1, 1'b1);
        tick(3);
        chk(topology === TOPO_LINE, "two primaries not line");
        ring_neighbours_inst.sync(1, 1'b0);
        tick(3);
        chk(topology === TOPO_RING, "primary and secondary not ring");
        chk(port_mode === MODE_FORWARD, "slave ip slot not forwarding");
        ip_one = '{valid: 1'b1, data: 8'h5A};
        ip_two = '{valid: 1'b1, data: 8'hA5};
        #1 chk(ip_one_ready === 1'b1 && ip_two_ready === 1'b1, "ip beat refused");
        tick(1);
        chk(tx_one.valid === 1'b1 && tx_one.data === 8'h5A, "ip beat lost on tx_one");
        chk(tx_two.valid === 1'b1 && tx_two.data === 8'hA5, "ip beat lost on tx_two");
        ip_one = BEAT_IDLE;
        ip_two = BEAT_IDLE;
        rt_slot = 1'b1;
        tick(3);
        ip_one = '{valid: 1'b1, data: 8'h5A};
        #1 chk(ip_one_ready === 1'b0, "ip beat taken in realtime slot");
        path(0, 8'h10, 1'b0, 1'b1);
        path(1, 8'h20, 1'b1, 1'b0);
        path(2, 8'h30, 1'b1, 1'b1);
        ip_one = BEAT_IDLE;
    endtask : t_topology

    task automatic t_first_sync;
        rt_slot = 1'b0;
        init_phase = 1'b1;
        do_reset();
        ring_neighbours_inst.sync(1, 1'b1);
        tick(3);
        chk(port_mode === MODE_FORWARD, "loopback in ip slot");
        rt_slot = 1'b1;
        tick(3);
        chk(port_mode === MODE_LOOP_TWO, "no loop on first sync port");
        path(1, 8'h40, 1'b1, 1'b1);
        ring_neighbours_inst.sync(0, 1'b1);
        tick(3);
        chk(port_mode === MODE_FORWARD, "loop kept after second sync");
        init_phase = 1'b0;
    endtask : t_first_sync

    task automatic t_link_loss;
        do_reset();
        ring_neighbours_inst.sync(0, 1'b1);
        ring_neighbours_inst.sync(1, 1'b1);
        tick(3);
        chk(port_mode === MODE_FORWARD, "loop with both ports alive");
        ring_neighbours_inst.link(1, 1'b0);
        tick(1);
        chk(link_lost === 2'b10, "link loss not flagged");
        tick(2);
        chk(port_mode === MODE_LOOP_ONE, "no heal loop on port one");
        path(0, 8'h60, 1'b1, 1'b1);
        lost_clear = 2'b10;
        tick(1);
        lost_clear = 2'b00;
        tick(1);
        chk(link_lost === 2'b00, "loss flag not cleared");
        rt_slot = 1'b0;
        tick(3);
        chk(port_mode === MODE_FORWARD, "loopback in ip slot");
        ring_neighbours_inst.link(1, 1'b1);
    endtask : t_link_loss

    task automatic t_master;
        is_master = 1'b1;
        rt_slot = 1'b1;
        ring_ok = 1'b1;
        do_reset();
        tick(2);
        chk(port_mode === MODE_BLOCK, "master forwards in rt slot");
        path(0, 8'h70, 1'b0, 1'b0);
        rt_slot = 1'b0;
        tick(3);
        chk(port_mode === MODE_BLOCK, "master forwards on intact ring");
        ring_ok = 1'b0;
        tick(3);
        chk(port_mode === MODE_FORWARD, "master blocks on faulty ring");
        path(1, 8'h80, 1'b1, 1'b0);
        ring_neighbours_inst.link(0, 1'b0);
        tick(3);
        chk(port_mode === MODE_BLOCK, "master forwards on single line");
        chk(link_lost === 2'b01, "port one loss not flagged");
    endtask : t_master

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        is_master = 1'b0;
        rt_slot = 1'b0;
        init_phase = 1'b0;
        ring_ok = 1'b0;
        lost_clear = 2'b00;
        ip_one = BEAT_IDLE;
        ip_two = BEAT_IDLE;
        t_topology();
        t_first_sync();
        t_link_loss();
        t_master();
        end_of_test();
    end

endmodule : ring_line_port_forwarding_tb
